/* File: verilog/lpcirq_pkg.sv */
package lpcirq_pkg;
   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_MASK   = 12'h008;
   localparam logic [11:0] ADDR_STATE  = 12'h00c;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int RX2_EN_BIT     = 2;
   localparam int RX3_EN_BIT     = 3;
   localparam int ABORT_BIT      = 4;
   localparam int BIDIR_EN_BIT   = 5;
   localparam int HW_SDWN_EN_BIT = 6;
   localparam int SOFT_RST_BIT   = 8;
   localparam int SOFT_SDWN_BIT  = 9;

   // ****************************************************************
   // Event status bits
   // ****************************************************************
   localparam int EV_ABORT = 0;
   localparam int EV_RX2   = 1;
   localparam int EV_RX3   = 2;
   localparam int EV_BIDIR = 3;
   localparam int EV_W     = 4;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [3:0]      CTRL_RESET = 4'h0;
   localparam logic [EV_W-1:0] EV_RESET   = 4'h0;
   localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
endpackage : lpcirq_pkg

/* File: verilog/lpcirq_sync_fall.sv */
// ****************************************************************
// Two-stage synchroniser with falling-edge pulse
// ****************************************************************
module lpcirq_sync_fall
   import lpcirq_pkg::*;
(
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic CE,
   input  wire logic PIN,
   output logic      LEVEL,
   output logic      FALL
);
   logic stage1;
   logic stage2;
   logic prev;

   // Idle high: a pin high at reset makes no edge, but one held low through reset gives one fall
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
         prev   <= 1'b1;
      end else if (CE) begin
         stage1 <= PIN;
         stage2 <= stage1;
         prev   <= stage2;
      end
   end

   assign LEVEL = stage2;
   assign FALL  = CE & prev & ~stage2;
endmodule : lpcirq_sync_fall

/* File: verilog/lpcirq_rx_gate.sv */
// ****************************************************************
// Receive interrupt gate: buffer-full AND enable, registered
// ****************************************************************
module lpcirq_rx_gate
   import lpcirq_pkg::*;
(
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic CE,
   input  wire logic FULL,
   input  wire logic ENABLE,
   output logic      IRQ,
   output logic      RISE
);
   logic next_irq;

   // Request follows status, so it holds until the buffer is read
   assign next_irq = FULL & ENABLE; // [RL14]

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else if (CE) begin
         IRQ <= next_irq;
      end
   end

   assign RISE = CE & next_irq & ~IRQ;
endmodule : lpcirq_rx_gate

/* File: verilog/lpcirq_top.sv */
// Operation
// (RL1) Falling LFRAME_N during a transfer cycle sets the abort flag.
// (RL2) Writing 1 to the soft reset bit clears the abort flag.
// (RL3) Shutdown enable high and falling LPCPD_N clears the abort flag.
// (RL4) Writing 1 to the soft shutdown bit clears the abort flag.
// (RL5) Rx3 and rx2 enables are read/write bits 3 and 2, reset 0.
// (RL6) Rx3 enable 0 blocks interrupts for input reg 3 and bidir buffer.
// (RL7) Rx3 enable 1, bidir enable 0: only input reg 3 interrupts.
// (RL8) Both enables 1: input reg 3 and bidir buffer interrupt.
// (RL9) Rx2 enable gates input reg 2 interrupt; 1 passes it.
// (RL10) Falling LRESET_N clears the abort flag.
// (RL11) Software clears abort by writing 0 after reading 1; 1 ignored.
// (RL12) Abort flag sits at bit 4, reset value 0, readable.
// (RL13) Any clearing condition beats a simultaneous abort set.
// (RL14) Each request is full status AND enable, held until status clears.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
module lpcirq_top
   import lpcirq_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        CE,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [11:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // LPC pins
   input  wire logic        LFRAME_N,
   input  wire logic        LRESET_N,
   input  wire logic        LPCPD_N,
   // From the LPC cycle engine, same clock
   input  wire logic        LPC_CYCLE_BUSY,
   input  wire logic        RX2_FULL,
   input  wire logic        RX3_FULL,
   input  wire logic        BIDIR_FULL,
   // Interrupt outputs
   output logic             RX2_IRQ,
   output logic             RX3_IRQ,
   output logic             BIDIR_IRQ,
   output logic             IRQ
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Pins are asynchronous; each passes two flops before any logic
   logic lframe_fall;
   logic lreset_fall;
   logic lpcpd_fall;
   logic lframe_lvl;
   logic lreset_lvl;
   logic lpcpd_lvl;

   lpcirq_sync_fall u_sync_frame (
      .CLOCK (CLOCK),
      .RST   (RST),
      .CE    (CE),
      .PIN   (LFRAME_N),
      .LEVEL (lframe_lvl),
      .FALL  (lframe_fall)
   );

   lpcirq_sync_fall u_sync_reset (
      .CLOCK (CLOCK),
      .RST   (RST),
      .CE    (CE),
      .PIN   (LRESET_N),
      .LEVEL (lreset_lvl),
      .FALL  (lreset_fall)
   );

   lpcirq_sync_fall u_sync_pd (
      .CLOCK (CLOCK),
      .RST   (RST),
      .CE    (CE),
      .PIN   (LPCPD_N),
      .LEVEL (lpcpd_lvl),
      .FALL  (lpcpd_fall)
   );

   // ****************************************************************
   // AHB-Lite slave, zero wait states
   // ****************************************************************
   logic        dp_write;
   logic        dp_read;
   logic [11:0] dp_addr;
   logic        addr_take;

   assign addr_take = CE & HSEL & HREADY & HTRANS[1];

   // Latch address phase; data phase follows in the next cycle
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_addr  <= 12'h000;
      end else if (CE) begin
         dp_write <= addr_take & HWRITE;
         dp_read  <= addr_take & ~HWRITE;
         dp_addr  <= HADDR;
      end
   end

   // Never stretches a transfer and never signals an error
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   logic wr_ctrl;
   logic wr_status;
   logic wr_mask;
   logic rd_ctrl;

   // Data-phase strobes: writes to control, status and mask, and control reads
   assign wr_ctrl   = CE & dp_write & (dp_addr == ADDR_CTRL);
   assign wr_status = CE & dp_write & (dp_addr == ADDR_STATUS);
   assign wr_mask   = CE & dp_write & (dp_addr == ADDR_MASK);
   assign rd_ctrl   = CE & dp_read & (dp_addr == ADDR_CTRL);

   // ****************************************************************
   // Control bits
   // ****************************************************************
   logic rx2_irq_enable;
   logic rx3_irq_enable;
   logic bidir_buffer_irq_enable;
   logic hw_shutdown_enable;

   // Enables and shutdown enable; command bits are strobes below
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         {hw_shutdown_enable, bidir_buffer_irq_enable,
          rx3_irq_enable, rx2_irq_enable} <= CTRL_RESET; // [RL5]
      end else if (wr_ctrl) begin
         rx2_irq_enable          <= HWDATA[RX2_EN_BIT]; // [RL5]
         rx3_irq_enable          <= HWDATA[RX3_EN_BIT]; // [RL5]
         bidir_buffer_irq_enable <= HWDATA[BIDIR_EN_BIT];
         hw_shutdown_enable      <= HWDATA[HW_SDWN_EN_BIT];
      end
   end

   // Self-clearing command bits; they act in the write cycle only
   logic lpc_soft_reset_bit;
   logic soft_shutdown_bit;

   assign lpc_soft_reset_bit = wr_ctrl & HWDATA[SOFT_RST_BIT];
   assign soft_shutdown_bit  = wr_ctrl & HWDATA[SOFT_SDWN_BIT];

   // ****************************************************************
   // Abort flag
   // ****************************************************************
   logic transfer_abort_flag;
   logic abort_seen;
   logic abort_set;
   logic abort_clr;
   logic sw_clear;

   // Read-1 arms the software clear, so a blind write of 0 is ignored
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         abort_seen <= 1'b0;
      end else if (CE) begin
         if (rd_ctrl & transfer_abort_flag) begin
            abort_seen <= 1'b1; // [RL11]
         end else if (~transfer_abort_flag) begin
            abort_seen <= 1'b0;
         end
      end
   end

   assign sw_clear  = wr_ctrl & abort_seen & ~HWDATA[ABORT_BIT]; // [RL11]
   assign abort_set = lframe_fall & LPC_CYCLE_BUSY; // [RL1]
   assign abort_clr = lreset_fall                   // [RL10]
                    | lpc_soft_reset_bit            // [RL2]
                    | (hw_shutdown_enable & lpcpd_fall) // [RL3]
                    | soft_shutdown_bit             // [RL4]
                    | sw_clear;

   // Clear beats a concurrent set so reset/shutdown always ends at 0
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         transfer_abort_flag <= 1'b0; // [RL12]
      end else if (CE) begin
         if (abort_clr) begin
            transfer_abort_flag <= 1'b0; // [RL13]
         end else if (abort_set) begin
            transfer_abort_flag <= 1'b1; // [RL1]
         end
      end
   end

   // ****************************************************************
   // Receive interrupt gating
   // ****************************************************************
   // Rise pulses feed the sticky status; the levels go straight out
   logic rx2_rise;
   logic rx3_rise;
   logic bidir_rise;

   lpcirq_rx_gate u_gate_rx2 (
      .CLOCK  (CLOCK),
      .RST    (RST),
      .CE     (CE),
      .FULL   (RX2_FULL),
      .ENABLE (rx2_irq_enable), // [RL9]
      .IRQ    (RX2_IRQ),
      .RISE   (rx2_rise)
   );

   lpcirq_rx_gate u_gate_rx3 (
      .CLOCK  (CLOCK),
      .RST    (RST),
      .CE     (CE),
      .FULL   (RX3_FULL),
      .ENABLE (rx3_irq_enable), // [RL6] [RL7]
      .IRQ    (RX3_IRQ),
      .RISE   (rx3_rise)
   );

   // Bidir buffer needs both its own and the channel 3 enable
   lpcirq_rx_gate u_gate_bidir (
      .CLOCK  (CLOCK),
      .RST    (RST),
      .CE     (CE),
      .FULL   (BIDIR_FULL),
      .ENABLE (rx3_irq_enable & bidir_buffer_irq_enable), // [RL6] [RL7] [RL8]
      .IRQ    (BIDIR_IRQ),
      .RISE   (bidir_rise)
   );

   // ****************************************************************
   // Sticky event status, mask and combined interrupt
   // ****************************************************************
   logic [EV_W-1:0] ev_status;
   logic [EV_W-1:0] ev_mask;
   logic [EV_W-1:0] ev_hit;
   logic [EV_W-1:0] ev_w1c;

   assign ev_hit[EV_ABORT] = abort_set & ~abort_clr;
   assign ev_hit[EV_RX2]   = rx2_rise;
   assign ev_hit[EV_RX3]   = rx3_rise;
   assign ev_hit[EV_BIDIR] = bidir_rise;
   assign ev_w1c = wr_status ? HWDATA[EV_W-1:0] : EV_RESET;

   // New events win over a write-one-to-clear in the same cycle
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ev_status <= EV_RESET;
      end else if (CE) begin
         ev_status <= (ev_status & ~ev_w1c) | ev_hit;
      end
   end

   // Mask register, same layout as status
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ev_mask <= MASK_RESET;
      end else if (wr_mask) begin
         ev_mask <= HWDATA[EV_W-1:0];
      end
   end

   // Level interrupt, high while any unmasked event stands
   assign IRQ = |(ev_status & ev_mask);

   // ****************************************************************
   // Read data, registered in the address phase
   // ****************************************************************
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (HADDR)
         ADDR_CTRL: begin
            next_rdata[RX2_EN_BIT]     = rx2_irq_enable;
            next_rdata[RX3_EN_BIT]     = rx3_irq_enable;
            next_rdata[ABORT_BIT]      = transfer_abort_flag; // [RL12]
            next_rdata[BIDIR_EN_BIT]   = bidir_buffer_irq_enable;
            next_rdata[HW_SDWN_EN_BIT] = hw_shutdown_enable;
         end
         ADDR_STATUS: next_rdata[EV_W-1:0] = ev_status;
         ADDR_MASK:   next_rdata[EV_W-1:0] = ev_mask;
         ADDR_STATE: begin
            next_rdata[0] = lframe_lvl;
            next_rdata[1] = lreset_lvl;
            next_rdata[2] = lpcpd_lvl;
            next_rdata[3] = LPC_CYCLE_BUSY;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Loaded at the address edge so data stands through the data phase
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (addr_take & ~HWRITE) begin
         HRDATA <= next_rdata;
      end
   end
endmodule : lpcirq_top

/* File: testbench/lpcirq_lpc_host.sv */
// ******
// LPC host side: frame, reset and power-down pins
// ******
module lpcirq_lpc_host (
   input  wire logic CLOCK,
   output logic      LFRAME_N,
   output logic      LRESET_N,
   output logic      LPCPD_N,
   output logic      LPC_CYCLE_BUSY
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus: all pins released high, no cycle running
   initial begin
      {LPCPD_N, LRESET_N, LFRAME_N} = 3'b111;
      LPC_CYCLE_BUSY = 1'b0;
   end

   // Pull chosen pins low; busy marks a cycle in flight when frame drops
   task automatic pulse(input logic [2:0] low, input logic busy);
      @(posedge CLOCK);
      LPC_CYCLE_BUSY <= busy;
      {LPCPD_N, LRESET_N, LFRAME_N} <= ~low;
      repeat (6) @(posedge CLOCK);
      {LPCPD_N, LRESET_N, LFRAME_N} <= 3'b111;
      LPC_CYCLE_BUSY <= 1'b0;
      // Tail covers the synchroniser delay before the next access
      repeat (6) @(posedge CLOCK);
   endtask : pulse
endmodule : lpcirq_lpc_host

/* File: testbench/lpcirq_asserts.sv */
// ******
// Port checker
// ******
module lpcirq_asserts
   import lpcirq_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        RST,
   input wire logic        HSEL,
   input wire logic [11:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        RX2_FULL,
   input wire logic        RX3_FULL,
   input wire logic        BIDIR_FULL,
   input wire logic        RX2_IRQ,
   input wire logic        RX3_IRQ,
   input wire logic        BIDIR_IRQ,
   input wire logic        IRQ
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   logic        wr_ph;
   logic [11:0] wr_a;
   logic [31:0] ctl;
   logic [3:0]  msk;
   wire         take = HSEL && HREADY && HTRANS[1];

   // Write address phase captured for the data phase
   always_ff @(posedge CLOCK) begin
      wr_ph <= !RST && take && HWRITE;
      wr_a  <= HADDR;
   end

   // Shadow copies of control and mask, as software last wrote them
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ctl <= 32'h0;
         msk <= 4'h0;
      end else if (wr_ph && wr_a == ADDR_CTRL) begin
         ctl <= HWDATA;
      end else if (wr_ph && wr_a == ADDR_MASK) begin
         msk <= HWDATA[3:0];
      end
   end

   a_reset_quiet: assert property ($fell(RST) |-> HRDATA == 32'h0 && !IRQ
      && !RX2_IRQ && !RX3_IRQ && !BIDIR_IRQ) else $error("outputs not quiet after reset");
   a_ctrl_readback: assert property (take && !HWRITE && HADDR == ADDR_CTRL |=>
      {HRDATA[9:8], HRDATA[6:5], HRDATA[3:2]} == {2'b00, $past(ctl[6:5]), $past(ctl[3:2])})
      else $error("control readback wrong");
   a_unmapped_zero: assert property (take && !HWRITE && HADDR > ADDR_STATE |=>
      HRDATA == 32'h0) else $error("unmapped read not zero");
   a_rx2_gate: assert property (RX2_IRQ == $past(RX2_FULL && ctl[RX2_EN_BIT]))
      else $error("rx2 request wrong");
   a_rx3_gate: assert property (RX3_IRQ == $past(RX3_FULL && ctl[RX3_EN_BIT]))
      else $error("rx3 request wrong");
   a_bidir_gate: assert property (BIDIR_IRQ ==
      $past(BIDIR_FULL && ctl[RX3_EN_BIT] && ctl[BIDIR_EN_BIT])) else $error("bidir request wrong");
   a_rx_drop: assert property (!RX2_FULL && !RX3_FULL |=> !RX2_IRQ && !RX3_IRQ)
      else $error("request outlived full status");
   a_irq_masked: assert property (IRQ |-> msk != 4'h0)
      else $error("interrupt without mask");
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus response not ready okay");
endmodule : lpcirq_asserts

bind lpcirq_top lpcirq_asserts u_chk (.CLOCK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
   .HREADY, .HRDATA, .HREADYOUT, .HRESP, .RX2_FULL, .RX3_FULL, .BIDIR_FULL, .RX2_IRQ,
   .RX3_IRQ, .BIDIR_IRQ, .IRQ);

/* File: testbench/tb_top.sv */
// ******
// Register-level bench
// ******
module tb_top
   import lpcirq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CLOCK = 1'b0, RST = 1'b1, CE = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
   logic        RX2_FULL = 1'b0, RX3_FULL = 1'b0, BIDIR_FULL = 1'b0;
   logic [1:0]  HTRANS = 2'b00;
   logic [2:0]  HSIZE = 3'h2;
   logic [11:0] HADDR = 12'h0;
   logic [31:0] HWDATA = 32'h0;
   wire  [31:0] HRDATA;
   wire         HREADYOUT, HRESP, HREADY, LFRAME_N, LRESET_N, LPCPD_N, LPC_CYCLE_BUSY;
   wire         RX2_IRQ, RX3_IRQ, BIDIR_IRQ, IRQ;
   int          failures = 0, num_checks = 0;
   logic [31:0] cfg [5] = '{32'h0, 32'h08, 32'h28, 32'h24, 32'h2c};
   logic [31:0] exp_irq;
   assign HREADY = HREADYOUT;

   lpcirq_top uut (.CLOCK, .RST, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
      .HREADY, .HRDATA, .HREADYOUT, .HRESP, .LFRAME_N, .LRESET_N, .LPCPD_N, .LPC_CYCLE_BUSY,
      .RX2_FULL, .RX3_FULL, .BIDIR_FULL, .RX2_IRQ, .RX3_IRQ, .BIDIR_IRQ, .IRQ);
   lpcirq_lpc_host host (.CLOCK, .LFRAME_N, .LRESET_N, .LPCPD_N, .LPC_CYCLE_BUSY);

   // 25 MHz clock
   always #20 CLOCK = ~CLOCK;

   // Compare and count; unknowns never match
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : check

   // One AHB-Lite single word transfer; waits on ready in both phases
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge CLOCK);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= w;
      HADDR <= a;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   // Read and compare under a bit mask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] m, e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(n, e, q & m);
   endtask : rd

   // Let registered outputs land before looking
   task automatic settle(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : settle

   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #100000;
      failures++;
      end_of_test();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge CLOCK);
      RST <= 1'b0;
      rd("ctrl reset", ADDR_CTRL, 32'hffffffff, 32'h0);
      rd("unmapped", 12'h010, 32'hffffffff, 32'h0);
      rd("pin state", ADDR_STATE, 32'hf, 32'h7);
      wr(ADDR_CTRL, 32'h36c);
      rd("ctrl rw", ADDR_CTRL, 32'h36c, 32'h6c);
      RX2_FULL <= 1'b1;
      RX3_FULL <= 1'b1;
      BIDIR_FULL <= 1'b1;
      // Five enable combinations, including bidir enable without rx3
      foreach (cfg[i]) begin
         wr(ADDR_CTRL, cfg[i]);
         settle(3);
         exp_irq = 32'({cfg[i][3] & cfg[i][5], cfg[i][3], cfg[i][2]});
         check("rx irqs", exp_irq, 32'({BIDIR_IRQ, RX3_IRQ, RX2_IRQ}));
      end
      RX2_FULL <= 1'b0;
      RX3_FULL <= 1'b0;
      BIDIR_FULL <= 1'b0;
      settle(3);
      check("irqs dropped", 32'h0, 32'({BIDIR_IRQ, RX3_IRQ, RX2_IRQ}));
      wr(ADDR_STATUS, 32'hf);
      host.pulse(3'b001, 1'b0);
      rd("no abort idle", ADDR_CTRL, 32'h10, 32'h0);
      host.pulse(3'b001, 1'b1);
      rd("abort set", ADDR_CTRL, 32'h10, 32'h10);
      rd("abort event", ADDR_STATUS, 32'hf, 32'h1);
      settle(1);
      check("irq masked", 32'h0, 32'(IRQ));
      wr(ADDR_MASK, 32'h1);
      settle(1);
      check("irq raised", 32'h1, 32'(IRQ));
      rd("mask rw", ADDR_MASK, 32'hf, 32'h1);
      wr(ADDR_STATUS, 32'h1);
      settle(1);
      check("irq cleared", 32'h0, 32'(IRQ));
      // The read above armed the software clear; disarm it with a soft reset
      wr(ADDR_CTRL, 32'h1 << SOFT_RST_BIT);
      rd("abort reset", ADDR_CTRL, 32'h10, 32'h0);
      // Each clearing path; kind 6 drops frame and reset together
      for (int k = 0; k < 7; k++) begin
         if (k != 6)
            host.pulse(3'b001, 1'b1);
         case (k)
            0: begin
               wr(ADDR_CTRL, 32'h0);
               rd("abort unread", ADDR_CTRL, 32'h10, 32'h10);
               wr(ADDR_CTRL, 32'h10);
               rd("abort kept", ADDR_CTRL, 32'h10, 32'h10);
               wr(ADDR_CTRL, 32'h0);
            end
            1: wr(ADDR_CTRL, 32'h1 << SOFT_RST_BIT);
            2: wr(ADDR_CTRL, 32'h1 << SOFT_SDWN_BIT);
            3: host.pulse(3'b010, 1'b0);
            4: host.pulse(3'b100, 1'b0);
            5: begin
               // Abort bit written as 1 so the armed software clear stays out
               wr(ADDR_CTRL, (32'h1 << HW_SDWN_EN_BIT) | (32'h1 << ABORT_BIT));
               host.pulse(3'b100, 1'b0);
            end
            default: host.pulse(3'b011, 1'b1);
         endcase
         rd("abort cleared", ADDR_CTRL, 32'h10, (k == 4) ? 32'h10 : 32'h0);
      end
      end_of_test();
   end
endmodule : tb_top
